// File: inc/dsg_pkg.sv
package dsg_pkg;

    // system-control block placement and register offsets
    localparam logic [31:0] SYSCTL_BASE = 32'h400fe000;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CAPABILITIES_1 = 12'h010;
    localparam logic [11:0] OFF_SOFTWARE_RESET_CTL_0 = 12'h040;
    localparam logic [11:0] OFF_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [11:0] OFF_RUN_CLOCK_GATE_2 = 12'h108;
    localparam logic [11:0] OFF_SLEEP_CLOCK_GATE_2 = 12'h118;
    localparam logic [11:0] OFF_DEEP_SLEEP_CLOCK_GATE_2 = 12'h128;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h150;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h154;

    // field layout
    localparam int NUM_PORTS = 5;
    localparam int PORT_IDX_W = 3;
    localparam int WATCHDOG_RESET_BIT = 3;
    localparam int AUTO_GATING_SELECT_BIT = 27;
    localparam int NUM_EVENTS = 2;
    localparam int EVT_PORT_FAULT = 0;
    localparam int EVT_WATCHDOG_RESET = 1;

    // reset values
    localparam logic [4:0] GATE_RESET = 5'h00;
    localparam logic [31:0] SW_RESET_CTL_0_RESET = 32'h00000000;
    localparam logic [1:0] EVT_RESET = 2'h0;
    // capability word: arbitrary default, only the watchdog-present bit matters here
    localparam logic [31:0] CAPABILITIES_1_DEFAULT = 32'h00000008;
    localparam logic [31:0] SW_RESET_CTL_0_WRITABLE = 32'h00000008;

    // apb answer timing: one wait state in every access
    localparam int APB_WAIT_CYCLES = 1;

    typedef enum logic [1:0] {
        DSG_MODE_RUN,
        DSG_MODE_SLEEP,
        DSG_MODE_DEEP
    } dsg_mode_e;

endpackage

// File: verilog/dsg_gate_sel.sv
`timescale 1ns/1ps
module dsg_gate_sel (
    // gating words
    input wire logic [4:0] run_gate,
    input wire logic [4:0] sleep_gate,
    input wire logic [4:0] deep_gate,
    // power state
    input wire dsg_pkg::dsg_mode_e mode,
    input wire logic auto_gating,
    // effective enables
    output logic [4:0] port_en
);

    genvar gi;
    generate
        for (gi = 0; gi < dsg_pkg::NUM_PORTS; gi = gi + 1) begin : g_port
            // low-power words only count when auto gating is selected
            always_comb begin
                if (auto_gating && mode == dsg_pkg::DSG_MODE_DEEP) begin
                    port_en[gi] = deep_gate[gi];
                end else if (auto_gating && mode == dsg_pkg::DSG_MODE_SLEEP) begin
                    port_en[gi] = sleep_gate[gi];
                end else begin
                    port_en[gi] = run_gate[gi];
                end
            end
        end
    endgenerate

endmodule

// File: verilog/dsg_ctl.sv
`timescale 1ns/1ps
// What this block does
// - each gating bit enables one port clock
// - access to unclocked port gives bus fault
// - gating bits reset to zero
// - separate run, sleep, deep-sleep gating words
// - low-power words apply only with auto gating
// - bits 0..4 gate ports a..e
// - unused bits read as zero
// - reset word bit 3 resets watchdog
// - capability word masks reset-word writes
// - deep-sleep word decodes at offset 0x128
module dsg_ctl #(
    parameter logic [31:0] CAPABILITIES_1_VALUE = dsg_pkg::CAPABILITIES_1_DEFAULT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power state requests from the core
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    // accesses aimed at the five ports
    input wire logic port_access_valid,
    input wire logic [2:0] port_access_idx,
    output logic port_fault,
    // port clock enables and watchdog reset
    output logic [4:0] port_clk_en,
    output logic watchdog_reset,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [4:0] run_gate_ff;
    logic [4:0] sleep_gate_ff;
    logic [4:0] deep_gate_ff;
    logic auto_gating_ff;
    logic watchdog_bit_ff;
    logic [1:0] evt_status_ff;
    logic [1:0] evt_mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic port_fault_ff;
    logic [4:0] port_clk_en_ff;
    logic irq_ff;
    dsg_pkg::dsg_mode_e mode_ff;
    dsg_pkg::dsg_mode_e nxt_mode;
    logic [4:0] nxt_port_en;
    logic [31:0] nxt_rdata;
    logic nxt_hit;
    logic wr_commit;
    logic access_wait;
    logic fault_now;
    logic watchdog_set_evt;
    logic [1:0] evt_set;
    logic [1:0] nxt_status;

    // one-hot of a port index; indices above port e select nothing
    function automatic logic [4:0] port_onehot(input logic [2:0] idx);
        logic [4:0] oh;
        oh = 5'h00;
        if (idx < 3'(dsg_pkg::NUM_PORTS)) begin
            oh[idx] = 1'b1;
        end
        return oh;
    endfunction

    // true when the write lands on a given offset
    function automatic logic hit_off(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    assign access_wait = psel && penable && !pready_ff;
    assign wr_commit = psel && penable && pready_ff && pwrite && !pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // power mode tracking; deep sleep wins over sleep

    always_comb begin
        case (mode_ff)
            dsg_pkg::DSG_MODE_RUN, dsg_pkg::DSG_MODE_SLEEP, dsg_pkg::DSG_MODE_DEEP: begin
                if (deep_sleep_req) begin
                    nxt_mode = dsg_pkg::DSG_MODE_DEEP;
                end else if (sleep_req) begin
                    nxt_mode = dsg_pkg::DSG_MODE_SLEEP;
                end else begin
                    nxt_mode = dsg_pkg::DSG_MODE_RUN;
                end
            end
            default: begin
                nxt_mode = dsg_pkg::DSG_MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= dsg_pkg::DSG_MODE_RUN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gating words

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_gate_ff <= dsg_pkg::GATE_RESET;
            sleep_gate_ff <= dsg_pkg::GATE_RESET;
            deep_gate_ff <= dsg_pkg::GATE_RESET;
        end else if (wr_commit) begin
            if (hit_off(paddr, dsg_pkg::OFF_RUN_CLOCK_GATE_2)) begin
                run_gate_ff <= pwdata[4:0];
            end
            if (hit_off(paddr, dsg_pkg::OFF_SLEEP_CLOCK_GATE_2)) begin
                sleep_gate_ff <= pwdata[4:0];
            end
            if (hit_off(paddr, dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2)) begin
                deep_gate_ff <= pwdata[4:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_gating_ff <= 1'b0;
        end else if (wr_commit && hit_off(paddr, dsg_pkg::OFF_RUN_CLOCK_CONFIG)) begin
            auto_gating_ff <= pwdata[dsg_pkg::AUTO_GATING_SELECT_BIT];
        end
    end

    dsg_gate_sel u_gate_sel (
        .run_gate(run_gate_ff),
        .sleep_gate(sleep_gate_ff),
        .deep_gate(deep_gate_ff),
        .mode(mode_ff),
        .auto_gating(auto_gating_ff),
        .port_en(nxt_port_en)
    );

    // the enable feeds clock gaters outside; registering it keeps them glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_clk_en_ff <= dsg_pkg::GATE_RESET;
        end else begin
            port_clk_en_ff <= nxt_port_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // port access fault: judged against the enable the port really sees

    assign fault_now = port_access_valid && ((port_onehot(port_access_idx) & ~port_clk_en_ff) != 5'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_fault_ff <= 1'b0;
        end else begin
            port_fault_ff <= fault_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software reset word, masked by capabilities

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_bit_ff <= dsg_pkg::SW_RESET_CTL_0_RESET[dsg_pkg::WATCHDOG_RESET_BIT];
        end else if (wr_commit && hit_off(paddr, dsg_pkg::OFF_SOFTWARE_RESET_CTL_0)
                     && CAPABILITIES_1_VALUE[dsg_pkg::WATCHDOG_RESET_BIT]) begin
            watchdog_bit_ff <= pwdata[dsg_pkg::WATCHDOG_RESET_BIT];
        end
    end

    assign watchdog_set_evt = wr_commit && hit_off(paddr, dsg_pkg::OFF_SOFTWARE_RESET_CTL_0)
                              && CAPABILITIES_1_VALUE[dsg_pkg::WATCHDOG_RESET_BIT]
                              && pwdata[dsg_pkg::WATCHDOG_RESET_BIT] && !watchdog_bit_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask; a new event beats a same-cycle clear

    assign evt_set = {watchdog_set_evt, fault_now};
    assign nxt_status = (wr_commit && hit_off(paddr, dsg_pkg::OFF_IRQ_STATUS))
                        ? ((evt_status_ff & ~pwdata[1:0]) | evt_set) : (evt_status_ff | evt_set);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status_ff <= dsg_pkg::EVT_RESET;
        end else begin
            evt_status_ff <= nxt_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask_ff <= dsg_pkg::EVT_RESET;
        end else if (wr_commit && hit_off(paddr, dsg_pkg::OFF_IRQ_MASK)) begin
            evt_mask_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            // follows the status as it will stand after this edge, so it changes on the same edge as the status flop
            irq_ff <= ((nxt_status & evt_mask_ff) != 2'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb read decode; reserved bits fill with zero

    always_comb begin
        nxt_rdata = 32'h00000000;
        nxt_hit = 1'b1;
        case (paddr)
            dsg_pkg::OFF_RUN_CLOCK_GATE_2: begin
                nxt_rdata[4:0] = run_gate_ff;
            end
            dsg_pkg::OFF_SLEEP_CLOCK_GATE_2: begin
                nxt_rdata[4:0] = sleep_gate_ff;
            end
            dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2: begin
                nxt_rdata[4:0] = deep_gate_ff;
            end
            dsg_pkg::OFF_SOFTWARE_RESET_CTL_0: begin
                nxt_rdata[dsg_pkg::WATCHDOG_RESET_BIT] = watchdog_bit_ff;
            end
            dsg_pkg::OFF_RUN_CLOCK_CONFIG: begin
                nxt_rdata[dsg_pkg::AUTO_GATING_SELECT_BIT] = auto_gating_ff;
            end
            dsg_pkg::OFF_CAPABILITIES_1: begin
                nxt_rdata = CAPABILITIES_1_VALUE;
            end
            dsg_pkg::OFF_IRQ_STATUS: begin
                nxt_rdata[1:0] = evt_status_ff;
            end
            dsg_pkg::OFF_IRQ_MASK: begin
                nxt_rdata[1:0] = evt_mask_ff;
            end
            default: begin
                nxt_hit = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'h0) begin
            nxt_hit = 1'b0;
        end
    end

    // one wait state: answer is built in the first access cycle and shown in the next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else if (access_wait) begin
            pready_ff <= 1'b1;
            pslverr_ff <= !nxt_hit;
            prdata_ff <= (pwrite || !nxt_hit) ? 32'h00000000 : nxt_rdata;
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port_fault = port_fault_ff;
    assign port_clk_en = port_clk_en_ff;
    assign watchdog_reset = watchdog_bit_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    logic first_cycle_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_cycle_ff <= 1'b1;
        end else begin
            first_cycle_ff <= 1'b0;
        end
    end

    sequence s_watchdog_write_one;
        psel && penable && pready && pwrite && !pslverr
        && paddr == dsg_pkg::OFF_SOFTWARE_RESET_CTL_0 && pwdata[3];
    endsequence

    sequence s_access_start;
        psel && !penable ##1 psel && penable;
    endsequence

    chk_fault_gated: assert property (@(posedge pclk) disable iff (!presetn)
        port_access_valid && port_access_idx < 3'h5 && !port_clk_en[port_access_idx] |=> port_fault)
        else $error("access to unclocked port gave no fault");

    chk_no_fault_clocked: assert property (@(posedge pclk) disable iff (!presetn)
        !port_access_valid || (port_access_idx < 3'h5 && port_clk_en[port_access_idx]) |=> !port_fault)
        else $error("fault raised for a clocked port");

    chk_gate_reset: assert property (@(posedge pclk) disable iff (!presetn)
        first_cycle_ff |-> port_clk_en == 5'h00 && deep_gate_ff == 5'h00 && !watchdog_reset)
        else $error("gating not zero after reset");

    chk_deep_gate: assert property (@(posedge pclk) disable iff (!presetn)
        mode_ff == dsg_pkg::DSG_MODE_DEEP && auto_gating_ff |=> port_clk_en == $past(deep_gate_ff))
        else $error("deep sleep enables not applied");

    chk_run_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !auto_gating_ff |=> port_clk_en == $past(run_gate_ff))
        else $error("low power word used without auto gating");

    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && !pslverr |->
        (paddr != dsg_pkg::OFF_SOFTWARE_RESET_CTL_0 || (prdata[31:4] == 28'h0 && prdata[2:0] == 3'h0))
        && (paddr != dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2 || prdata[31:5] == 27'h0))
        else $error("reserved bits read non zero");

    chk_watchdog_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s_watchdog_write_one |=> watchdog_reset == CAPABILITIES_1_VALUE[3])
        else $error("watchdog reset bit not taken");

    chk_cap_mask: assert property (@(posedge pclk) disable iff (!presetn)
        !CAPABILITIES_1_VALUE[3] |-> !watchdog_reset)
        else $error("masked reset bit changed");

    chk_watchdog_stable: assert property (@(posedge pclk) disable iff (!presetn)
        watchdog_reset && !(psel && penable && pready && pwrite) |=> watchdog_reset)
        else $error("watchdog released without a write");

    chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_access_start |-> ##1 pready)
        else $error("apb answer not after one wait state");

    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ((evt_status_ff & evt_mask_ff) != 2'h0) [*2] |-> irq)
        else $error("interrupt low with unmasked status");

    chk_deep_decode: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && !pslverr && paddr == 12'h128 |=> deep_gate_ff == $past(pwdata[4:0]))
        else $error("deep sleep word not written at its offset");

endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, sleep_req, deep_sleep_req, port_access_valid;
    logic pready, pslverr, port_fault, watchdog_reset, irq, err, watchdog_nocap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [2:0] port_access_idx;
    logic [4:0] port_clk_en;
    int n_mismatch, compares;
    ////////////////////////////////////////////////////////////////////////
    dsg_ctl dsg_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .port_access_valid(port_access_valid),
        .port_access_idx(port_access_idx), .port_fault(port_fault), .port_clk_en(port_clk_en),
        .watchdog_reset(watchdog_reset), .irq(irq));
    // second copy reports no watchdog, so its reset word must ignore writes
    dsg_ctl #(.CAPABILITIES_1_VALUE(32'h00000000)) dsg_ctl_inst_nocap (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
        .port_access_valid(port_access_valid), .port_access_idx(port_access_idx), .port_fault(),
        .port_clk_en(), .watchdog_reset(watchdog_nocap), .irq());
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // master holds the request until pready is seen at an edge; wait is bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            $display("mismatch pready expected 1 seen timeout");
            print_verdict();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic access(input logic [2:0] idx, input logic exp);
        @(posedge pclk);
        port_access_valid <= 1'b1;
        port_access_idx <= idx;
        @(posedge pclk);
        port_access_valid <= 1'b0;
        #1;
        check("port_fault", {31'h0, port_fault}, {31'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic sc_reset();
        rd(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2);
        check("deep_gate_rst", rdata, 32'h00000000);
        rd(dsg_pkg::OFF_SOFTWARE_RESET_CTL_0);
        check("sw_reset_rst", rdata, 32'h00000000);
        check("port_clk_en_rst", {27'h0, port_clk_en}, 32'h00000000);
        check("watchdog_rst", {31'h0, watchdog_reset}, 32'h00000000);
    endtask
    task automatic sc_decode();
        rd(12'h12c);
        check("unmapped_err", {31'h0, err}, 32'h00000001);
        wr(12'h12a, 32'h0000001f);
        check("misaligned_err", {31'h0, err}, 32'h00000001);
        rd(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2);
        check("deep_gate_decode", rdata, 32'h00000000);
        check("deep_gate_err", {31'h0, err}, 32'h00000000);
    endtask
    task automatic sc_fault();
        wr(dsg_pkg::OFF_RUN_CLOCK_GATE_2, 32'h00000001);
        wr(dsg_pkg::OFF_IRQ_MASK, 32'h00000001);
        step(2);
        access(3'h0, 1'b0);
        access(3'h2, 1'b1);
        check("irq_set", {31'h0, irq}, 32'h00000001);
        rd(dsg_pkg::OFF_IRQ_STATUS);
        check("status_fault", rdata, 32'h00000001);
        wr(dsg_pkg::OFF_IRQ_STATUS, 32'h00000001);
        step(2);
        check("irq_clr", {31'h0, irq}, 32'h00000000);
        access(3'h5, 1'b0);
        wr(dsg_pkg::OFF_IRQ_MASK, 32'h00000000);
        access(3'h4, 1'b1);
        step(1);
        check("irq_masked", {31'h0, irq}, 32'h00000000);
        wr(dsg_pkg::OFF_IRQ_STATUS, 32'h00000003);
    endtask
    task automatic sc_fields();
        wr(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2, 32'hffffffff);
        rd(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2);
        check("deep_gate_bits", rdata, 32'h0000001f);
        wr(dsg_pkg::OFF_SOFTWARE_RESET_CTL_0, 32'hffffffff);
        rd(dsg_pkg::OFF_SOFTWARE_RESET_CTL_0);
        check("sw_reset_bits", rdata, 32'h00000008);
        check("watchdog_held", {31'h0, watchdog_reset}, 32'h00000001);
        check("watchdog_nocap", {31'h0, watchdog_nocap}, 32'h00000000);
        rd(dsg_pkg::OFF_IRQ_STATUS);
        check("status_watchdog", rdata, 32'h00000002);
        // read-modify-write keeps whatever the reserved bits show
        rd(dsg_pkg::OFF_SOFTWARE_RESET_CTL_0);
        wr(dsg_pkg::OFF_SOFTWARE_RESET_CTL_0, rdata & 32'hfffffff7);
        step(1);
        check("watchdog_free", {31'h0, watchdog_reset}, 32'h00000000);
        wr(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2, 32'h00000000);
        wr(dsg_pkg::OFF_IRQ_STATUS, 32'h00000003);
    endtask
    task automatic sc_select();
        wr(dsg_pkg::OFF_SLEEP_CLOCK_GATE_2, 32'h00000002);
        wr(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2, 32'h00000004);
        @(posedge pclk);
        deep_sleep_req <= 1'b1;
        step(3);
        check("no_auto_deep", {27'h0, port_clk_en}, 32'h00000001);
        wr(dsg_pkg::OFF_RUN_CLOCK_CONFIG, 32'h1 << dsg_pkg::AUTO_GATING_SELECT_BIT);
        step(2);
        check("auto_deep", {27'h0, port_clk_en}, 32'h00000004);
        @(posedge pclk);
        deep_sleep_req <= 1'b0;
        sleep_req <= 1'b1;
        step(3);
        check("auto_sleep", {27'h0, port_clk_en}, 32'h00000002);
        @(posedge pclk);
        sleep_req <= 1'b0;
        step(3);
        check("auto_run", {27'h0, port_clk_en}, 32'h00000001);
        @(posedge pclk);
        deep_sleep_req <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_2, 32'h1 << i);
            step(2);
            check("port_bit", {27'h0, port_clk_en}, 32'h1 << i);
            access(3'(i), 1'b0);
            access(3'((i + 1) % 5), 1'b1);
        end
        @(posedge pclk);
        deep_sleep_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_mismatch = 0;
        compares = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        sleep_req = 1'b0;
        deep_sleep_req = 1'b0;
        port_access_valid = 1'b0;
        port_access_idx = 3'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset();
        sc_decode();
        sc_fault();
        sc_fields();
        sc_select();
        step(2);
        print_verdict();
    end
endmodule
